// [hw/rbl_params.svh]
/*
  Constants for the receive ring overflow recovery controller: device register
  offsets and values, software register map, field positions and timing counts.
  Assumes a 50 MHz controller clock and an 8-bit device register port.
*/
`ifndef RBL_PARAMS_SVH
`define RBL_PARAMS_SVH

// ==========================================================================
// clock and timing
// ==========================================================================
`define RBL_CLK_NS 20
`define RBL_STOP_WAIT_US 1600
`define RBL_STOP_WAIT_CYC ((`RBL_STOP_WAIT_US * 1000 + `RBL_CLK_NS - 1) / `RBL_CLK_NS)
`define RBL_WR_CYC 3'h2
`define RBL_RD_CYC 3'h4

// ==========================================================================
// device register offsets (page 0)
// ==========================================================================
`define RBL_DEV_CMD 4'h0
`define RBL_DEV_ISR 4'h7
`define RBL_DEV_RCNT_LO 4'hA
`define RBL_DEV_RCNT_HI 4'hB
`define RBL_DEV_TCFG 4'hD

// ==========================================================================
// device values and bits
// ==========================================================================
`define RBL_CMD_STOP 8'h21
`define RBL_CMD_START 8'h22
`define RBL_CMD_START_TX 8'h26
`define RBL_CMD_TXREQ_BIT 2
`define RBL_ISR_TXDONE_BIT 1
`define RBL_ISR_TXERR_BIT 3
`define RBL_ISR_OVW_CLR 8'h10
`define RBL_TCFG_LOOP1 8'h02
`define RBL_TCFG_LOOP2 8'h04
`define RBL_TCFG_LOOP_MASK 8'h06

// ==========================================================================
// software register map
// ==========================================================================
`define RBL_SW_CTRL 4'h0
`define RBL_SW_STATUS 4'h1
`define RBL_SW_TCFG_NORM 4'h2
`define RBL_SW_DEV_ADDR 4'h3
`define RBL_SW_DEV_WR 4'h4
`define RBL_SW_DEV_RD 4'h5
`define RBL_CTRL_START 0
`define RBL_CTRL_DRAINED 1
`define RBL_CTRL_LOOP2 2
`define RBL_CTRL_NO_RDMA 3
`define RBL_STAT_DONE_BIT 4
`define RBL_TCFG_NORM_RST 8'h00

`endif

// [hw/rbl_pkg.sv]
/*
  Types for the receive ring overflow recovery controller.
  Assumes rbl_params.svh supplies all numeric constants.
*/
package rbl_pkg;

  typedef enum logic [3:0] {
    STEP_IDLE, STEP_RD_CMD, STEP_STOP, STEP_WAIT, STEP_RCNT_LO, STEP_RCNT_HI,
    STEP_RD_ISR, STEP_LOOP, STEP_START, STEP_DRAIN, STEP_CLR_OVW, STEP_NORMAL,
    STEP_RESEND
  } rbl_step_t;

  typedef enum logic [1:0] {
    ACC_IDLE, ACC_WR, ACC_RD
  } rbl_acc_t;

endpackage

// [hw/rbl_host.sv]
/*
  Host-side controller that runs the receive ring overflow recovery routine on
  the network controller through its register port, plus direct register access
  for software (packet removal while the routine waits).
  Assumes the device latches a write while its write strobe is high and drives
  read data while its read strobe is high; read data is asynchronous here.
*/
`timescale 1ns/100ps
`include "rbl_params.svh"

// Function
// - host saves transmit request bit, then writes 21H to stop.
// - host waits at least 1.6 ms, ignoring the reset status bit.
// - host clears both remote byte count registers.
// - resend marked only if transmit request saved and no done/error flag.
// - loopback mode 1 is 0,1 and mode 2 is 1,0 on D2,D1.
// - writing 22H starts controller, activating remote DMA channel.
// - host clears ring overflow flag after removing packets.
// - host restores normal transmit configuration with loopback bits zero.
// - marked resend is cleared and 26H written: start plus transmit request.
// - without remote DMA, packets may be removed before start.
module rbl_host
  import rbl_pkg::*;
#(
  parameter int unsigned STOP_WAIT_CYC = `RBL_STOP_WAIT_CYC
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic [3:0] SW_ADDR_I,
  input wire logic [7:0] SW_WDATA_I,
  input wire logic SW_WR_I,
  input wire logic SW_RD_I,
  output logic [7:0] SW_RDATA_O,
  output logic [3:0] DEV_ADDR_O,
  output logic [7:0] DEV_DATA_O,
  output logic DEV_WR_O,
  output logic DEV_RD_O,
  input wire logic [7:0] DEV_DATA_I
);

  // ========================================================================
  // read data synchroniser
  // ========================================================================
  logic [7:0] dsync1;
  logic [7:0] dsync2;

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      dsync1 <= 8'h00;
      dsync2 <= 8'h00;
    end else begin
      dsync1 <= DEV_DATA_I;
      dsync2 <= dsync1;
    end
  end

  // ========================================================================
  // software registers
  // ========================================================================
  logic start_pend, drained_pend, loop2, no_rdma, done_flag;
  logic dir_pend, dir_wr;
  logic [3:0] dir_addr;
  logic [7:0] dir_wdata, dir_rdata, tcfg_norm, sw_rdata;
  logic next_start_pend, next_drained_pend, next_loop2, next_no_rdma, next_done_flag;
  logic next_dir_pend, next_dir_wr;
  logic [3:0] next_dir_addr;
  logic [7:0] next_dir_wdata, next_dir_rdata, next_tcfg_norm, next_sw_rdata;
  // sequencer / engine handshake terms
  rbl_step_t step, next_step;
  rbl_acc_t acc, next_acc;
  logic start_take, drained_take, done_set, dir_grant, dir_done;
  logic saved_txreq, resend;
  logic seq_req, seq_wr, acc_done, acc_owner_dir;
  logic [3:0] seq_addr;
  logic [7:0] seq_data;

  always_comb begin
    next_start_pend = start_pend & ~start_take;
    next_drained_pend = drained_pend & ~drained_take & ~start_take;
    next_loop2 = loop2;
    next_no_rdma = no_rdma;
    next_done_flag = done_flag;
    next_dir_pend = dir_pend & ~dir_grant;
    next_dir_wr = dir_wr;
    next_dir_addr = dir_addr;
    next_dir_wdata = dir_wdata;
    next_dir_rdata = dir_rdata;
    next_tcfg_norm = tcfg_norm;
    next_sw_rdata = 8'h00;
    if (dir_done && !dir_wr) begin
      next_dir_rdata = dsync2;
    end
    if (SW_WR_I) begin
      unique case (SW_ADDR_I)
        `RBL_SW_CTRL: begin
          if (SW_WDATA_I[`RBL_CTRL_START]) begin
            next_start_pend = 1'b1;
          end
          if (SW_WDATA_I[`RBL_CTRL_DRAINED]) begin
            next_drained_pend = 1'b1;
          end
          next_loop2 = SW_WDATA_I[`RBL_CTRL_LOOP2];
          next_no_rdma = SW_WDATA_I[`RBL_CTRL_NO_RDMA];
        end
        `RBL_SW_STATUS: begin
          if (SW_WDATA_I[`RBL_STAT_DONE_BIT]) begin
            next_done_flag = 1'b0;
          end
        end
        `RBL_SW_TCFG_NORM: next_tcfg_norm = SW_WDATA_I;
        `RBL_SW_DEV_ADDR: next_dir_addr = SW_WDATA_I[3:0];
        `RBL_SW_DEV_WR: begin
          next_dir_wdata = SW_WDATA_I;
          next_dir_wr = 1'b1;
          next_dir_pend = 1'b1;
        end
        `RBL_SW_DEV_RD: begin
          next_dir_wr = 1'b0;
          next_dir_pend = 1'b1;
        end
        default: ;
      endcase
    end
    // hardware set beats a software clear in the same cycle
    if (done_set) begin
      next_done_flag = 1'b1;
    end
    if (SW_RD_I) begin
      unique case (SW_ADDR_I)
        `RBL_SW_CTRL: next_sw_rdata = {4'h0, no_rdma, loop2, 2'h0};
        `RBL_SW_STATUS: next_sw_rdata = {2'h0, dir_pend, done_flag, saved_txreq,
                                         step == STEP_DRAIN, resend, step != STEP_IDLE};
        `RBL_SW_TCFG_NORM: next_sw_rdata = tcfg_norm;
        `RBL_SW_DEV_ADDR: next_sw_rdata = {4'h0, dir_addr};
        `RBL_SW_DEV_RD: next_sw_rdata = dir_rdata;
        default: next_sw_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      start_pend <= 1'b0;
      drained_pend <= 1'b0;
      loop2 <= 1'b0;
      no_rdma <= 1'b0;
      done_flag <= 1'b0;
      dir_pend <= 1'b0;
      dir_wr <= 1'b0;
      dir_addr <= 4'h0;
      dir_wdata <= 8'h00;
      dir_rdata <= 8'h00;
      tcfg_norm <= `RBL_TCFG_NORM_RST;
      sw_rdata <= 8'h00;
    end else begin
      start_pend <= next_start_pend;
      drained_pend <= next_drained_pend;
      loop2 <= next_loop2;
      no_rdma <= next_no_rdma;
      done_flag <= next_done_flag;
      dir_pend <= next_dir_pend;
      dir_wr <= next_dir_wr;
      dir_addr <= next_dir_addr;
      dir_wdata <= next_dir_wdata;
      dir_rdata <= next_dir_rdata;
      tcfg_norm <= next_tcfg_norm;
      sw_rdata <= next_sw_rdata;
    end
  end

  assign SW_RDATA_O = sw_rdata;

  // ========================================================================
  // device access engine
  // ========================================================================
  // the routine has priority; software access waits while a step is on the port
  logic [2:0] acc_cnt, next_acc_cnt;
  logic next_owner_dir, next_dev_wr, next_dev_rd;
  logic [3:0] next_dev_addr;
  logic [7:0] next_dev_data;

  always_comb begin
    next_acc = acc;
    next_acc_cnt = acc_cnt + 3'h1;
    next_owner_dir = acc_owner_dir;
    next_dev_addr = DEV_ADDR_O;
    next_dev_data = DEV_DATA_O;
    dir_grant = 1'b0;
    acc_done = 1'b0;
    unique case (acc)
      ACC_IDLE: begin
        next_acc_cnt = 3'h0;
        if (seq_req) begin
          next_acc = seq_wr ? ACC_WR : ACC_RD;
          next_owner_dir = 1'b0;
          next_dev_addr = seq_addr;
          next_dev_data = seq_data;
        end else if (dir_pend) begin
          dir_grant = 1'b1;
          next_acc = dir_wr ? ACC_WR : ACC_RD;
          next_owner_dir = 1'b1;
          next_dev_addr = dir_addr;
          next_dev_data = dir_wdata;
        end
      end
      ACC_WR: begin
        if (acc_cnt == `RBL_WR_CYC - 3'h1) begin
          acc_done = 1'b1;
          next_acc = ACC_IDLE;
        end
      end
      ACC_RD: begin
        // strobe long enough for data to pass both synchroniser stages
        if (acc_cnt == `RBL_RD_CYC - 3'h1) begin
          acc_done = 1'b1;
          next_acc = ACC_IDLE;
        end
      end
      default: next_acc = ACC_IDLE;
    endcase
    next_dev_wr = next_acc == ACC_WR;
    next_dev_rd = next_acc == ACC_RD;
  end

  assign dir_done = acc_done & acc_owner_dir;

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      acc <= ACC_IDLE;
      acc_cnt <= 3'h0;
      acc_owner_dir <= 1'b0;
      DEV_ADDR_O <= 4'h0;
      DEV_DATA_O <= 8'h00;
      DEV_WR_O <= 1'b0;
      DEV_RD_O <= 1'b0;
    end else begin
      acc <= next_acc;
      acc_cnt <= next_acc_cnt;
      acc_owner_dir <= next_owner_dir;
      DEV_ADDR_O <= next_dev_addr;
      DEV_DATA_O <= next_dev_data;
      DEV_WR_O <= next_dev_wr;
      DEV_RD_O <= next_dev_rd;
    end
  end

  // ========================================================================
  // overflow recovery sequencer
  // ========================================================================
  logic [16:0] wait_cnt, next_wait_cnt;
  logic next_saved_txreq, next_resend, seq_done;

  assign seq_done = acc_done & ~acc_owner_dir;

  always_comb begin
    next_step = step;
    next_wait_cnt = wait_cnt;
    next_saved_txreq = saved_txreq;
    next_resend = resend;
    seq_req = 1'b0;
    seq_wr = 1'b1;
    seq_addr = `RBL_DEV_CMD;
    seq_data = 8'h00;
    start_take = 1'b0;
    drained_take = 1'b0;
    done_set = 1'b0;
    unique case (step)
      STEP_IDLE: begin
        if (start_pend) begin
          start_take = 1'b1;
          next_resend = 1'b0;
          next_step = STEP_RD_CMD;
        end
      end
      STEP_RD_CMD: begin
        seq_req = 1'b1;
        seq_wr = 1'b0;
        if (seq_done) begin
          next_saved_txreq = dsync2[`RBL_CMD_TXREQ_BIT];
          next_step = STEP_STOP;
        end
      end
      STEP_STOP: begin
        seq_req = 1'b1;
        seq_data = `RBL_CMD_STOP;
        if (seq_done) begin
          next_wait_cnt = 17'h00000;
          next_step = STEP_WAIT;
        end
      end
      STEP_WAIT: begin
        // fixed time-out only; the reset status bit is not trusted
        next_wait_cnt = wait_cnt + 17'h00001;
        if (wait_cnt == 17'(STOP_WAIT_CYC - 1)) begin
          next_step = STEP_RCNT_LO;
        end
      end
      STEP_RCNT_LO: begin
        seq_req = 1'b1;
        seq_addr = `RBL_DEV_RCNT_LO;
        if (seq_done) begin
          next_step = STEP_RCNT_HI;
        end
      end
      STEP_RCNT_HI: begin
        seq_req = 1'b1;
        seq_addr = `RBL_DEV_RCNT_HI;
        if (seq_done) begin
          next_step = saved_txreq ? STEP_RD_ISR : STEP_LOOP;
        end
      end
      STEP_RD_ISR: begin
        seq_req = 1'b1;
        seq_wr = 1'b0;
        seq_addr = `RBL_DEV_ISR;
        if (seq_done) begin
          next_resend = ~(dsync2[`RBL_ISR_TXDONE_BIT] | dsync2[`RBL_ISR_TXERR_BIT]);
          next_step = STEP_LOOP;
        end
      end
      STEP_LOOP: begin
        seq_req = 1'b1;
        seq_addr = `RBL_DEV_TCFG;
        seq_data = loop2 ? `RBL_TCFG_LOOP2 : `RBL_TCFG_LOOP1;
        if (seq_done) begin
          next_step = no_rdma ? STEP_DRAIN : STEP_START;
        end
      end
      STEP_START: begin
        seq_req = 1'b1;
        seq_data = `RBL_CMD_START;
        if (seq_done) begin
          next_step = no_rdma ? STEP_CLR_OVW : STEP_DRAIN;
        end
      end
      STEP_DRAIN: begin
        // software removes packets with direct access, then reports drained
        if (drained_pend) begin
          drained_take = 1'b1;
          next_step = no_rdma ? STEP_START : STEP_CLR_OVW;
        end
      end
      STEP_CLR_OVW: begin
        seq_req = 1'b1;
        seq_addr = `RBL_DEV_ISR;
        seq_data = `RBL_ISR_OVW_CLR;
        if (seq_done) begin
          next_step = STEP_NORMAL;
        end
      end
      STEP_NORMAL: begin
        seq_req = 1'b1;
        seq_addr = `RBL_DEV_TCFG;
        seq_data = tcfg_norm & ~`RBL_TCFG_LOOP_MASK;
        if (seq_done) begin
          next_step = resend ? STEP_RESEND : STEP_IDLE;
          done_set = ~resend;
        end
      end
      STEP_RESEND: begin
        seq_req = 1'b1;
        seq_data = `RBL_CMD_START_TX;
        if (seq_done) begin
          next_resend = 1'b0;
          done_set = 1'b1;
          next_step = STEP_IDLE;
        end
      end
      default: next_step = STEP_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      step <= STEP_IDLE;
      wait_cnt <= 17'h00000;
      saved_txreq <= 1'b0;
      resend <= 1'b0;
    end else begin
      step <= next_step;
      wait_cnt <= next_wait_cnt;
      saved_txreq <= next_saved_txreq;
      resend <= next_resend;
    end
  end

endmodule

// [testbench/rbl_host_props.sv]
/*
  Checker for the overflow recovery controller's device-side port.
  Assumes it is bound to rbl_host and sees only that module's ports.
*/
`timescale 1ns/100ps
module rbl_host_props #(
  parameter int unsigned STOP_WAIT_CYC = 20
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic [3:0] DEV_ADDR_O,
  input wire logic [7:0] DEV_DATA_O,
  input wire logic DEV_WR_O,
  input wire logic DEV_RD_O
);
  // ==========================================================================
  // idle time after the stop command
  // ==========================================================================
  logic armed;
  logic next_armed;
  logic [31:0] idle_cnt;
  logic [31:0] next_idle_cnt;
  logic stop_wr;
  assign stop_wr = DEV_WR_O && DEV_ADDR_O == 4'h0 && DEV_DATA_O == 8'h21;
  always_comb begin
    next_armed = armed;
    next_idle_cnt = idle_cnt;
    if (stop_wr) begin
      next_armed = 1'b1;
      next_idle_cnt = '0;
    end else if (DEV_WR_O || DEV_RD_O) begin
      next_armed = 1'b0;
    end else begin
      next_idle_cnt = idle_cnt + 32'h1;
    end
  end
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      armed <= 1'b0;
      idle_cnt <= '0;
    end else begin
      armed <= next_armed;
      idle_cnt <= next_idle_cnt;
    end
  end
  // ==========================================================================
  // assertions
  // ==========================================================================
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  a_cmd_value: assert property (DEV_WR_O && DEV_ADDR_O == 4'h0 |-> DEV_DATA_O inside {8'h21, 8'h22, 8'h26})
    else $error("command write with unexpected value");
  a_rcnt_clear: assert property (DEV_WR_O && DEV_ADDR_O inside {4'hA, 4'hB} |-> DEV_DATA_O == 8'h00)
    else $error("remote count written nonzero");
  a_loop_sel: assert property (DEV_WR_O && DEV_ADDR_O == 4'hD |-> DEV_DATA_O[2:1] != 2'b11)
    else $error("transmit config with illegal loopback select");
  a_isr_clear: assert property (DEV_WR_O && DEV_ADDR_O == 4'h7 |-> DEV_DATA_O == 8'h10)
    else $error("status write clears more than overflow");
  // counted from the end of the stop strobe, so two strobe cycles are credited
  a_stop_quiet: assert property (armed && !stop_wr && (DEV_WR_O || DEV_RD_O) |-> idle_cnt >= STOP_WAIT_CYC - 2)
    else $error("device accessed too soon after stop");
  a_wr_pulse: assert property ($rose(DEV_WR_O) |=> DEV_WR_O ##1 !DEV_WR_O)
    else $error("write strobe not two cycles");
  a_rd_pulse: assert property ($rose(DEV_RD_O) |=> DEV_RD_O [*3] ##1 !DEV_RD_O)
    else $error("read strobe not four cycles");
  a_wr_hold: assert property (DEV_WR_O && $past(DEV_WR_O) |-> $stable(DEV_ADDR_O) && $stable(DEV_DATA_O))
    else $error("address or data moved during write");
  cover property (DEV_WR_O && DEV_ADDR_O == 4'h0 && DEV_DATA_O == 8'h26);
  cover property ($rose(DEV_RD_O) && DEV_ADDR_O == 4'h7);
  cover property (DEV_WR_O && DEV_ADDR_O == 4'hD && DEV_DATA_O == 8'h04);
endmodule

// [testbench/rbl_dev_model.sv]
/*
  Behavioural model of the network controller's register port with an access log.
  Assumes the host holds address and data steady while a strobe is high.
*/
`timescale 1ns/100ps
module rbl_dev_model (
  input wire logic clk_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] data_o
);
  // ==========================================================================
  // registers and access log
  // ==========================================================================
  logic [7:0] regs [16];
  logic [44:0] log_q [$];
  logic [31:0] cyc = '0;
  logic [7:0] last = 8'h5A;
  logic wr_q = 1'b0;
  logic rd_q = 1'b0;
  // released bus shows the inverse of the last read, so stale data never matches
  assign data_o = rd_i ? regs[addr_i] : ~last;
  always @(posedge clk_i) begin
    cyc <= cyc + 32'h1;
    wr_q <= wr_i;
    rd_q <= rd_i;
    if (rd_i) last <= regs[addr_i];
    if (rd_i && !rd_q) log_q.push_back({cyc, 1'b0, addr_i, 8'h00});
    if (wr_i && !wr_q) begin
      log_q.push_back({cyc, 1'b1, addr_i, data_i});
      if (addr_i == 4'h7) regs[7] <= regs[7] & ~data_i;
      else regs[addr_i] <= data_i;
    end
  end
  // ==========================================================================
  // receive ring linker, fed one packet at a time by the bench
  // ==========================================================================
  logic [7:0] ring_start, ring_stop, bnd;
  logic [15:0] dma;
  logic rx_off;
  int missed;
  int pages;
  task automatic ring_setup(input logic [7:0] s, e, b, c);
    ring_start = s;
    ring_stop = e;
    bnd = b;
    dma = {c, 8'h00};
    rx_off = 1'b0;
    missed = 0;
  endtask
  // dma ends on the address of the last byte stored; an abort leaves it at the page end
  task automatic rx_packet(input int n);
    logic [7:0] nxt;
    pages = 1;
    if (rx_off || regs[0][0]) begin
      if (!regs[0][0]) missed++;
      return;
    end
    dma[7:0] = 8'h04;
    for (int i = 1; i < n; i++) begin
      dma[7:0] = dma[7:0] + 8'h01;
      if (dma[7:0] == 8'h00) begin
        nxt = dma[15:8] + 8'h01;
        if (nxt == ring_stop) nxt = ring_start;
        if (nxt == bnd) begin
          rx_off = 1'b1;
          regs[7][4] = 1'b1;
          missed++;
          dma[7:0] = 8'hFF;
          return;
        end
        dma[15:8] = nxt;
        pages++;
      end
    end
  endtask
endmodule

// [testbench/test_rbl_host.sv]
/*
  Self-checking bench for the overflow recovery controller.
  Assumes the device model on the far side and the checker bound below.
*/
`timescale 1ns/100ps
module test_rbl_host;
  localparam int WAITC = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] sw_addr = 4'h0;
  logic [7:0] sw_wdata = 8'h00;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [7:0] sw_rdata, dev_wdata, dev_rdata, rd;
  logic [3:0] dev_addr;
  logic dev_wr, dev_rd;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [12:0] exp_q [$];

  rbl_host #(.STOP_WAIT_CYC(WAITC)) i_rbl_host (.CLK_I(clk), .RST_N_I(rst_n), .SW_ADDR_I(sw_addr),
    .SW_WDATA_I(sw_wdata), .SW_WR_I(sw_wr), .SW_RD_I(sw_rd), .SW_RDATA_O(sw_rdata), .DEV_ADDR_O(dev_addr),
    .DEV_DATA_O(dev_wdata), .DEV_WR_O(dev_wr), .DEV_RD_O(dev_rd), .DEV_DATA_I(dev_rdata));
  rbl_dev_model i_rbl_dev_model (.clk_i(clk), .addr_i(dev_addr), .data_i(dev_wdata), .wr_i(dev_wr),
    .rd_i(dev_rd), .data_o(dev_rdata));

  // ==========================================================================
  // software port tasks
  // ==========================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    if (bad_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // each access waits an edge first, so a release and the next raise never share a step
  task automatic sw_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask
  task automatic wait_status(input int b, input logic v);
    logic [7:0] s;
    for (int n = 0; n < 300; n++) begin
      sw_read(4'h1, s);
      if (s[b] === v) return;
    end
    check(s[b], v);
  endtask

  // ==========================================================================
  // one recovery run: 0 resend, 1 loop2 without remote dma, 2 no tx pending
  // ==========================================================================
  task automatic run_routine(input int k);
    logic [7:0] ctrl;
    ctrl = (k == 1) ? 8'h0C : 8'h00;
    i_rbl_dev_model.regs[0] = (k == 2) ? 8'h22 : 8'h26;
    i_rbl_dev_model.regs[7] = (k == 1) ? 8'h12 : 8'h10;
    i_rbl_dev_model.regs[10] = 8'hFF;
    i_rbl_dev_model.regs[11] = 8'hFF;
    i_rbl_dev_model.log_q.delete();
    exp_q = '{13'h0000, 13'h1021, 13'h1A00, 13'h1B00};
    if (k != 2) exp_q.push_back(13'h0700);
    exp_q.push_back((k == 1) ? 13'h1D04 : 13'h1D02);
    exp_q.push_back(13'h1022);
    exp_q.push_back(13'h1710);
    exp_q.push_back(13'h1DE1);
    if (k == 0) exp_q.push_back(13'h1026);
    sw_write(4'h1, 8'h10);
    sw_write(4'h0, ctrl | 8'h01);
    wait_status(2, 1'b1);
    sw_read(4'h0, rd);
    check(rd, ctrl & 8'h0C);
    sw_read(4'h1, rd);
    check(rd[3:1], {k != 2, 1'b1, k == 0});
    if (k == 1) i_rbl_dev_model.rx_packet(60);
    check(i_rbl_dev_model.missed, 2);
    check(i_rbl_dev_model.regs[0], (k == 1) ? 8'h21 : 8'h22);
    check(i_rbl_dev_model.regs[13], (k == 1) ? 8'h04 : 8'h02);
    check({i_rbl_dev_model.regs[10], i_rbl_dev_model.regs[11]}, 16'h0000);
    sw_write(4'h0, ctrl | 8'h02);
    wait_status(4, 1'b1);
    sw_read(4'h1, rd);
    check(rd[1:0], 2'b00);
    check(i_rbl_dev_model.regs[7][4], 1'b0);
    check(i_rbl_dev_model.regs[13], 8'hE1);
    check(i_rbl_dev_model.regs[0], (k == 0) ? 8'h26 : 8'h22);
    check(i_rbl_dev_model.log_q.size(), exp_q.size());
    foreach (exp_q[i]) begin
      if (i < i_rbl_dev_model.log_q.size()) check(i_rbl_dev_model.log_q[i][12:0], exp_q[i]);
    end
    if (i_rbl_dev_model.log_q.size() > 2) begin
      check(i_rbl_dev_model.log_q[2][44:13] - i_rbl_dev_model.log_q[1][44:13] >= WAITC, 1'b1);
    end
  endtask

  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      check(32'h0, 32'h1);
      final_report();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    sw_read(4'h1, rd);
    check(rd, 8'h00);
    sw_read(4'h2, rd);
    check(rd, 8'h00);
    sw_write(4'hF, 8'hFF);
    sw_read(4'hF, rd);
    check(rd, 8'h00);
    sw_write(4'h3, 8'h00);
    sw_write(4'h4, 8'h26);
    wait_status(5, 1'b0);
    sw_write(4'h5, 8'h00);
    wait_status(5, 1'b0);
    // pending drops at grant; the four-cycle device read lands later
    repeat (4) @(posedge clk);
    sw_read(4'h5, rd);
    check(rd, 8'h26);
    sw_write(4'h2, 8'hE7);
    sw_read(4'h2, rd);
    check(rd, 8'hE7);
    i_rbl_dev_model.regs[0] = 8'h22;
    i_rbl_dev_model.regs[7] = 8'h00;
    i_rbl_dev_model.ring_setup(8'h40, 8'h50, 8'h4F, 8'h40);
    i_rbl_dev_model.rx_packet(1518);
    check(i_rbl_dev_model.dma, 16'h45F1);
    check(i_rbl_dev_model.pages, 6);
    i_rbl_dev_model.ring_setup(8'h40, 8'h44, 8'h42, 8'h43);
    i_rbl_dev_model.rx_packet(600);
    check(i_rbl_dev_model.dma, 16'h415B);
    i_rbl_dev_model.ring_setup(8'h40, 8'h44, 8'h42, 8'h40);
    i_rbl_dev_model.rx_packet(600);
    check(i_rbl_dev_model.dma, 16'h41FF);
    check(i_rbl_dev_model.regs[7], 8'h10);
    i_rbl_dev_model.rx_packet(60);
    check(i_rbl_dev_model.missed, 2);
    for (int k = 0; k < 3; k++) run_routine(k);
    final_report();
  end
endmodule

bind rbl_host rbl_host_props #(.STOP_WAIT_CYC(STOP_WAIT_CYC)) i_rbl_host_props (.CLK_I(CLK_I),
  .RST_N_I(RST_N_I), .DEV_ADDR_O(DEV_ADDR_O), .DEV_DATA_O(DEV_DATA_O), .DEV_WR_O(DEV_WR_O), .DEV_RD_O(DEV_RD_O));
